// ---- hdl/pse_pkg.sv ----
// constants and types shared by the pattern sequence engine
package pse_pkg;
  // ----------------------------------------------------------------
  // frame geometry and plane layout
  // ----------------------------------------------------------------
  localparam int PSE_COLS       = 912;        // mirror columns
  localparam int PSE_ROWS       = 1140;       // mirror rows
  localparam int PSE_PLANES     = 24;         // planes per source image
  localparam int PSE_MAX_DEPTH  = 8;          // deepest pattern
  localparam int PSE_IMAGES     = 64;         // flash image slots
  localparam int PSE_ENTRIES    = 16;         // sequence table depth
  // green planes at 0..7, red at 8..15, blue at 16..23
  localparam logic [4:0] PSE_GREEN_BASE = 5'h00;
  localparam logic [4:0] PSE_RED_BASE   = 5'h08;
  localparam logic [4:0] PSE_BLUE_BASE  = 5'h10;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int PSE_CLK_HZ      = 40_000_000;
  localparam int PSE_US_CYCLES   = PSE_CLK_HZ / 1_000_000;  // cycles per microsecond
  localparam logic [5:0] PSE_US_LAST = 6'(PSE_US_CYCLES - 1);
  localparam logic [23:0] PSE_LOAD_US    = 24'd230;       // pattern load time, us
  localparam logic [23:0] PSE_MIN_EXP_US = 24'd235;       // shortest exposure, us
  // pattern count limit per bit depth (index = depth)
  localparam logic [4:0] PSE_PAT_LIMIT [0:8] = '{5'h00, 5'h10, 5'h0C, 5'h08, 5'h06, 5'h04, 5'h04, 5'h03, 5'h03};
  // ----------------------------------------------------------------
  // sequence entry layout
  // ----------------------------------------------------------------
  localparam int PSE_E_LED   = 0;   // 3 bits led selection
  localparam int PSE_E_DEPTH = 3;   // 4 bits depth 1..8
  localparam int PSE_E_IMG   = 7;   // 6 bits image or frame index
  localparam int PSE_E_PLANE = 13;  // 5 bits first plane
  localparam int PSE_E_TRIG  = 18;  // 2 bits trigger choice
  localparam int PSE_E_BLANK = 20;  // blank after exposure
  localparam int PSE_E_INV   = 21;  // invert data
  localparam int PSE_E_W     = 22;
  localparam logic [PSE_E_W-1:0] PSE_ENTRY_RST = 22'h000000;
  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PSE_LED_WHITE, PSE_LED_CYAN, PSE_LED_MAGENTA, PSE_LED_YELLOW,
    PSE_LED_RED, PSE_LED_GREEN, PSE_LED_BLUE, PSE_LED_NONE
  } pse_led_e;
  typedef enum logic [1:0] {
    PSE_TRIG_NONE, PSE_TRIG_EXT_RISE, PSE_TRIG_EXT_FALL, PSE_TRIG_INT
  } pse_trig_e;
  localparam logic PSE_SRC_FLASH   = 1'b0;
  localparam logic PSE_SRC_VIDEO   = 1'b1;
  localparam logic PSE_MODE_INTEXT = 1'b0;
  localparam logic PSE_MODE_VSYNC  = 1'b1;
endpackage : pse_pkg

// ---- hdl/pse_engine.sv ----
// pattern sequence engine: table, validation, trigger sequencing, plane extraction
//
// Notes on behaviour
// - planes 1..8 deep at 912x1140
// - pixel data passed unscaled, unprocessed
// - source is flash image or video port
// - each entry holds led, depth, index, plane, trigger
// - period timer starts; gate input starts/pauses in int/ext mode only
// - internal waits period, external waits trigger input
// - exposure sets show time, period sets spacing
// - seven led colour combinations encoded
// - play once shows first N, else repeats
// - trigger none, rise, fall, internal
// - video source always triggers on vsync
// - planes green, red, blue; fixed grouping
// - blank array after exposure when flagged
// - flag period under exposure plus 230us
// - separate validation error flags
// - idle until play; pause and resume
// - untriggered patterns expose back to back
// - invert shows complement of plane data
// - one frame gives 3 to 16 patterns
module pse_engine
  import pse_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              entry_wr_i,             // table write strobe
  input  wire logic [3:0]        entry_idx_i,            // table slot
  input  wire logic [PSE_E_W-1:0] entry_data_i,          // entry fields
  input  wire logic [4:0]        entry_count_i,          // entries in sequence
  input  wire logic              source_i,               // flash or video
  input  wire logic              trig_mode_i,            // int/ext or vsync
  input  wire logic              gate_en_i,              // use gate input
  input  wire logic [23:0]       exposure_us_i,          // exposure, us
  input  wire logic [23:0]       period_us_i,            // period, us
  input  wire logic              play_once_i,            // stop after N
  input  wire logic [4:0]        pats_per_pulse_i,       // N for play once
  input  wire logic              validate_i,             // validate pulse
  input  wire logic              play_i,                 // play pulse
  input  wire logic              pause_i,                // pause pulse
  input  wire logic              stop_i,                 // stop pulse
  input  wire logic              sequence_gate_input_i,  // start/pause gate
  input  wire logic              advance_trig_i,         // advance trigger
  input  wire logic              vsync_i,                // video sync
  input  wire logic [23:0]       pixel_i,                // source pixel
  output logic                   led_red_o,
  output logic                   led_green_o,
  output logic                   led_blue_o,
  output logic [7:0]             plane_data_o,           // mirror data
  output logic [5:0]             image_index_o,
  output logic [4:0]             plane_index_o,
  output logic [3:0]             bit_depth_o,
  output logic                   exposing_o,
  output logic                   blank_o,
  output logic                   running_o,
  output logic                   valid_o,
  output logic                   timing_range_error_o,
  output logic                   pattern_count_error_o,
  output logic                   trig_overlap_error_o,
  output logic                   black_vector_error_o,
  output logic                   load_time_error_o
);
  // ----------------------------------------------------------------
  // sequence table
  // ----------------------------------------------------------------
  typedef enum {ST_STOP, ST_TRIG, ST_EXP, ST_PAUSE} pse_state_e;
  logic [PSE_E_W-1:0] table_q [PSE_ENTRIES];   // entry storage
  logic [PSE_ENTRIES-1:0] over_lim;            // per entry depth or count too high
  logic [PSE_ENTRIES-1:0] has_blank;           // per entry blank flag
  // one write port, entries held in flops
  for (genvar g = 0; g < PSE_ENTRIES; g++) begin : g_tab
    logic [PSE_E_W-1:0] next_ent;
    logic [3:0]         dep;
    always_comb begin
      next_ent = (entry_wr_i && entry_idx_i == 4'(g)) ? entry_data_i : table_q[g];
    end
    always_ff @(posedge sys_clk_i) begin
      table_q[g] <= rst_n_i ? next_ent : PSE_ENTRY_RST;
    end
    assign dep          = table_q[g][PSE_E_DEPTH +: 4];
    assign over_lim[g]  = (5'(g) < entry_count_i) && (dep > 4'd8 || entry_count_i > PSE_PAT_LIMIT[dep]);
    assign has_blank[g] = (5'(g) < entry_count_i) && table_q[g][PSE_E_BLANK];
  end
  // ----------------------------------------------------------------
  // validation
  // ----------------------------------------------------------------
  logic e_rng, e_cnt, e_ovl, e_blk, e_load, cfg_ok;
  logic [3:0] last_idx;
  always_comb begin
    last_idx = 4'(entry_count_i - 5'd1);
    e_rng  = exposure_us_i < PSE_MIN_EXP_US || period_us_i < exposure_us_i;
    e_cnt  = entry_count_i == 5'd0 || (|over_lim);
    e_ovl  = period_us_i == exposure_us_i && (|has_blank);
    e_blk  = play_once_i && entry_count_i != 5'd0 && !table_q[last_idx][PSE_E_BLANK];
    e_load = 25'(period_us_i) < 25'(exposure_us_i) + 25'(PSE_LOAD_US);
    cfg_ok = !(e_rng | e_cnt | e_ovl | e_blk | e_load);
  end
  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  pse_state_e state, next_state;
  logic [3:0]  idx, next_idx;           // current entry
  logic [4:0]  shown, next_shown;       // patterns shown this pass
  logic [5:0]  pre, next_pre;           // microsecond prescaler
  logic [23:0] exp_us, next_exp_us;     // exposure elapsed
  logic [23:0] per_us, next_per_us;     // period elapsed, saturating
  logic        adv_q, vs_q;             // edge history
  logic        blank_q, next_blank;
  logic [PSE_E_W-1:0] ent;
  logic        tick, vmode, fire, hold, seq_end;
  logic [3:0]  inc_idx;
  always_comb begin
    ent     = table_q[idx];
    tick    = pre == PSE_US_LAST;
    vmode   = trig_mode_i == PSE_MODE_VSYNC || source_i == PSE_SRC_VIDEO;
    // gate low with gate_en_i set blocks triggers and freezes exposure in int/ext mode
    hold    = !vmode && gate_en_i && !sequence_gate_input_i;
    inc_idx = (5'(idx) + 5'd1 >= entry_count_i) ? 4'h0 : idx + 4'h1;
    seq_end = play_once_i && shown + 5'd1 >= pats_per_pulse_i;
    if (vmode) begin
      fire = (idx == 4'h0) ? (vsync_i && !vs_q) : 1'b1;
    end else begin
      case (pse_trig_e'(ent[PSE_E_TRIG +: 2]))
        PSE_TRIG_NONE:     fire = 1'b1;
        PSE_TRIG_EXT_RISE: fire = advance_trig_i && !adv_q;
        PSE_TRIG_EXT_FALL: fire = !advance_trig_i && adv_q;
        PSE_TRIG_INT:      fire = per_us >= period_us_i;
        default:           fire = 1'b0;
      endcase
    end
  end
  // next state and counters
  always_comb begin
    next_state  = state;
    next_idx    = idx;
    next_shown  = shown;
    next_blank  = blank_q;
    next_pre    = tick ? 6'h00 : pre + 6'h01;
    next_exp_us = (tick && exp_us != 24'hFFFFFF) ? exp_us + 24'h1 : exp_us;
    next_per_us = (tick && per_us != 24'hFFFFFF) ? per_us + 24'h1 : per_us;
    case (state)
      ST_STOP: begin
        next_idx    = 4'h0;
        next_shown  = 5'h00;
        // blank level kept, so the array stays dark after the last pattern
        next_per_us = 24'hFFFFFF;          // first internal trigger is due at once
        if (play_i && valid_o) begin
          next_state = ST_TRIG;
        end
      end
      ST_TRIG: begin
        if (stop_i) begin
          next_state = ST_STOP;
        end else if (pause_i) begin
          next_state = ST_PAUSE;
        end else if (fire && !hold) begin
          next_state  = ST_EXP;
          next_blank  = 1'b0;
          next_pre    = 6'h00;
          next_exp_us = 24'h0;
          next_per_us = 24'h0;
        end
      end
      ST_EXP: begin
        if (stop_i) begin
          next_state = ST_STOP;
        end else if (pause_i) begin
          next_state = ST_PAUSE;
        end else if (hold) begin
          next_pre    = pre;               // frozen while gate is low
          next_exp_us = exp_us;
          next_per_us = per_us;
        end else if (tick && exp_us + 24'h1 >= exposure_us_i) begin
          next_blank = ent[PSE_E_BLANK];
          next_shown = shown + 5'd1;
          next_idx   = inc_idx;
          next_state = seq_end ? ST_STOP : ST_TRIG;
        end
      end
      ST_PAUSE: begin
        // resume restarts the interrupted pattern from its trigger
        if (stop_i) begin
          next_state = ST_STOP;
        end else if (play_i) begin
          next_state = ST_TRIG;
        end
      end
      default: next_state = ST_STOP;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state   <= ST_STOP;
      idx     <= 4'h0;
      shown   <= 5'h00;
      pre     <= 6'h00;
      exp_us  <= 24'h0;
      per_us  <= 24'h0;
      adv_q   <= 1'b0;
      vs_q    <= 1'b0;
      blank_q <= 1'b0;
    end else begin
      state   <= next_state;
      idx     <= next_idx;
      shown   <= next_shown;
      pre     <= next_pre;
      exp_us  <= next_exp_us;
      per_us  <= next_per_us;
      adv_q   <= advance_trig_i;
      vs_q    <= vsync_i;
      blank_q <= next_blank;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic [PSE_E_W-1:0] nent;
  logic [3:0]  ndep;
  logic [7:0]  mask, raw;
  logic [2:0]  next_led;
  logic [7:0]  next_data;
  logic        next_valid;
  logic [4:0]  next_errs;
  always_comb begin
    nent = table_q[next_idx];
    ndep = (nent[PSE_E_DEPTH +: 4] > 4'd8) ? 4'd8 : nent[PSE_E_DEPTH +: 4];
    mask = 8'(9'h0FF >> (4'd8 - ndep));
    // direct bit selection, no scaling or gamma on this path
    raw  = 8'(pixel_i >> nent[PSE_E_PLANE +: 5]) & mask;
    next_data = (next_state == ST_EXP) ? (raw ^ (nent[PSE_E_INV] ? mask : 8'h00)) : 8'h00;
    case (pse_led_e'(nent[PSE_E_LED +: 3]))
      PSE_LED_WHITE:   next_led = 3'h7;
      PSE_LED_CYAN:    next_led = 3'h6;
      PSE_LED_MAGENTA: next_led = 3'h5;
      PSE_LED_YELLOW:  next_led = 3'h3;
      PSE_LED_RED:     next_led = 3'h1;
      PSE_LED_GREEN:   next_led = 3'h2;
      PSE_LED_BLUE:    next_led = 3'h4;
      default:         next_led = 3'h0;
    endcase
    if (next_state != ST_EXP) begin
      next_led = 3'h0;
    end
    next_valid = valid_o;
    next_errs  = {timing_range_error_o, pattern_count_error_o, trig_overlap_error_o,
                  black_vector_error_o, load_time_error_o};
    if (validate_i && state == ST_STOP) begin
      next_valid = cfg_ok;
      next_errs  = {e_rng, e_cnt, e_ovl, e_blk, e_load};
    end else if (entry_wr_i && state == ST_STOP) begin
      next_valid = 1'b0;                   // table change needs a new validation
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      {led_blue_o, led_green_o, led_red_o} <= 3'h0;
      plane_data_o  <= 8'h00;
      image_index_o <= 6'h00;
      plane_index_o <= 5'h00;
      bit_depth_o   <= 4'h0;
      exposing_o    <= 1'b0;
      blank_o       <= 1'b0;
      running_o     <= 1'b0;
      valid_o       <= 1'b0;
      {timing_range_error_o, pattern_count_error_o, trig_overlap_error_o,
       black_vector_error_o, load_time_error_o} <= 5'h00;
    end else begin
      {led_blue_o, led_green_o, led_red_o} <= next_led;
      plane_data_o  <= next_data;
      image_index_o <= nent[PSE_E_IMG +: 6];
      plane_index_o <= nent[PSE_E_PLANE +: 5];
      bit_depth_o   <= ndep;
      exposing_o    <= next_state == ST_EXP;
      blank_o       <= next_blank;
      running_o     <= next_state != ST_STOP;
      valid_o       <= next_valid;
      {timing_range_error_o, pattern_count_error_o, trig_overlap_error_o,
       black_vector_error_o, load_time_error_o} <= next_errs;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_start; state == ST_TRIG ##1 state == ST_EXP; endsequence
  sequence s_end; state == ST_EXP ##1 state != ST_EXP; endsequence
  property p_leds_off_stopped;
    state == ST_STOP |=> !led_red_o && !led_green_o && !led_blue_o;
  endproperty
  a_leds_off_stopped: assert property (p_leds_off_stopped) else $error("leds lit while stopped");
  property p_play_needs_valid;
    state == ST_STOP && !valid_o |=> state == ST_STOP;
  endproperty
  a_play_needs_valid: assert property (p_play_needs_valid) else $error("started without validation");
  property p_exp_led;
    s_start |-> exposing_o;
  endproperty
  a_exp_led: assert property (p_exp_led) else $error("exposure not flagged");
  property p_blank_after;
    s_end ##0 $past(ent[PSE_E_BLANK]) && !$past(stop_i) && !$past(pause_i) |-> blank_o;
  endproperty
  a_blank_after: assert property (p_blank_after) else $error("no blank after exposure");
  property p_load_err;
    validate_i && state == ST_STOP && period_us_i < exposure_us_i |=> load_time_error_o && !valid_o;
  endproperty
  a_load_err: assert property (p_load_err) else $error("short period not flagged");
  property p_range_err;
    validate_i && state == ST_STOP && exposure_us_i < PSE_MIN_EXP_US |=> timing_range_error_o;
  endproperty
  a_range_err: assert property (p_range_err) else $error("exposure range not flagged");
  property p_none_b2b;
    s_end ##0 state == ST_TRIG && !vmode && !hold && !stop_i && !pause_i
      && ent[PSE_E_TRIG +: 2] == 2'(PSE_TRIG_NONE) |=> state == ST_EXP;
  endproperty
  a_none_b2b: assert property (p_none_b2b) else $error("untriggered pattern waited");
  property p_gate_hold;
    state == ST_EXP && hold && !stop_i && !pause_i |=> $stable(exp_us) && state == ST_EXP;
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gate low did not pause");
  property p_once_stop;
    state == ST_EXP && next_state == ST_STOP && !stop_i |-> play_once_i;
  endproperty
  a_once_stop: assert property (p_once_stop) else $error("stopped without play once");
  property p_ext_wait;
    state == ST_TRIG && !vmode && ent[PSE_E_TRIG +: 2] == 2'(PSE_TRIG_EXT_RISE)
      && !(advance_trig_i && !adv_q) |=> state != ST_EXP;
  endproperty
  a_ext_wait: assert property (p_ext_wait) else $error("advanced without trigger edge");
endmodule : pse_engine

// ---- verif/pse_video_src.sv ----
// video source and camera trigger model facing the sequence engine
module pse_video_src (
  input  wire logic        clk_i,    // bench clock
  output logic             vsync_o,  // frame sync
  output logic             trig_o,   // camera advance trigger
  output logic [23:0]      pixel_o   // streamed pixel
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // frame shape and content
  // ----------------------------------------------------------------
  localparam int          FRAME_COLS = 912;
  localparam int          FRAME_ROWS = 1140;
  localparam logic [23:0] FRAME_PIX  = 24'hA5C33C;    // flat frame, every pixel alike
  // one source only drives the port, so the lines never float
  initial begin
    vsync_o = 1'b0;
    trig_o  = 1'b0;
    pixel_o = FRAME_PIX;
  end
  // sync pulse launched off the falling edge, a few cycles wide
  task automatic vsync_pulse;
    @(negedge clk_i);
    vsync_o = 1'b1;
    repeat (4) @(negedge clk_i);
    vsync_o = 1'b0;
  endtask : vsync_pulse
  // camera advance pulse, rising and falling edge four cycles apart
  task automatic trig_pulse;
    @(negedge clk_i);
    trig_o = 1'b1;
    repeat (4) @(negedge clk_i);
    trig_o = 1'b0;
  endtask : trig_pulse
endmodule : pse_video_src

// ---- verif/testbench.sv ----
// self-checking bench for the pattern sequence engine
module testbench
  import pse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               wr = 1'b0, val = 1'b0, play = 1'b0, pause = 1'b0, stop = 1'b0;
  logic               mode = 1'b0, once = 1'b0, gate_en = 1'b0, gate = 1'b0;
  logic [3:0]         idx = 4'h0;
  logic [PSE_E_W-1:0] data = '0;
  logic [4:0]         cnt = 5'h00, npp = 5'h00;
  logic [23:0]        exp_us = 24'h0, per_us = 24'h0;
  wire                vs, trg;
  wire  [23:0]        pix;
  logic               r, g, b, expo, blank, run, valid, e_rng, e_cnt, e_ovl, e_blk, e_ld;
  logic [7:0]         pd;
  logic [4:0]         pi;
  logic [5:0]         ii;
  logic [3:0]         bd;
  int                 fails = 0, num_checks = 0, n;
  always #12.5 clk = ~clk;  // 40 MHz
  pse_video_src i_src (.clk_i(clk), .vsync_o(vs), .trig_o(trg), .pixel_o(pix));
  pse_engine i_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .entry_wr_i(wr), .entry_idx_i(idx), .entry_data_i(data),
    .entry_count_i(cnt), .source_i(PSE_SRC_FLASH), .trig_mode_i(mode), .gate_en_i(gate_en), .exposure_us_i(exp_us),
    .period_us_i(per_us), .play_once_i(once), .pats_per_pulse_i(npp), .validate_i(val), .play_i(play),
    .pause_i(pause), .stop_i(stop), .sequence_gate_input_i(gate), .advance_trig_i(trg), .vsync_i(vs),
    .pixel_i(pix), .led_red_o(r), .led_green_o(g), .led_blue_o(b), .plane_data_o(pd), .image_index_o(ii),
    .plane_index_o(pi), .bit_depth_o(bd), .exposing_o(expo), .blank_o(blank), .running_o(run), .valid_o(valid),
    .timing_range_error_o(e_rng), .pattern_count_error_o(e_cnt), .trig_overlap_error_o(e_ovl),
    .black_vector_error_o(e_blk), .load_time_error_o(e_ld));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  // entry word: invert, blank, trigger, plane, index equal to plane, depth, led
  function automatic logic [PSE_E_W-1:0] ent(logic [2:0] led, logic [3:0] d, logic [4:0] pl, logic [1:0] tr,
                                             logic bl, logic inv);
    return {inv, bl, tr, pl, {1'b0, pl}, d, led};
  endfunction : ent
  task automatic chk(string nm, logic [23:0] seen, logic [23:0] want);
    num_checks++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, want, seen);
    end
  endtask : chk
  task automatic end_sim;
    if (fails == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // one-cycle strobe, raised and dropped on falling edges
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  task automatic wr_ent(logic [3:0] i, logic [PSE_E_W-1:0] d);
    @(negedge clk);
    wr = 1'b1;
    idx = i;
    data = d;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_ent
  // flags packed as range, count, overlap, black, load, valid
  task automatic check_val(logic [23:0] e, logic [23:0] p, logic [4:0] c, logic o, logic [5:0] want);
    exp_us = e;
    per_us = p;
    cnt = c;
    once = o;
    pulse(val);
    @(negedge clk);
    chk("flags", {e_rng, e_cnt, e_ovl, e_blk, e_ld, valid}, want);
  endtask : check_val
  // bounded wait for the exposure level
  task automatic wait_for(logic lvl);
    n = 0;
    while (expo !== lvl && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk("wait", n < 20000, 1'b1);
  endtask : wait_for
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    chk("idle", {r, g, b, expo, run, valid, pd}, 0);
    wr_ent(4'h0, ent(3'h5, 4'h1, 5'h03, 2'h3, 1'b0, 1'b0));
    wr_ent(4'h1, ent(3'h0, 4'h8, 5'h08, 2'h0, 1'b1, 1'b1));
    npp = 5'h02;
    check_val(100, 470, 2, 1, 6'b100000);
    check_val(300, 235, 2, 1, 6'b100010);
    check_val(235, 235, 2, 1, 6'b001010);
    check_val(235, 470, 0, 0, 6'b010000);
    check_val(235, 470, 1, 1, 6'b000100);
    check_val(235, 470, 2, 1, 6'b000001);
    repeat (50) @(negedge clk);
    chk("held", {expo, run}, 0);
    pulse(play);
    @(negedge clk);
    chk("run", run, 1);
    wait_for(1'b1);
    chk("led0", {r, g, b}, 3'b010);
    chk("data0", {pd, pi, bd}, {8'h01, 5'h03, 4'h1});
    chk("index0", ii, 6'h03);
    n = 0;
    // full exposure length in clock cycles
    while (expo === 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk("exposure", n, 235 * 40);
    n = 0;
    while (expo !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("gap", n <= 4, 1'b1);
    chk("led1", {r, g, b}, 3'b111);
    chk("data1", pd, 8'h3C);
    wait_for(1'b0);
    repeat (3) @(negedge clk);
    chk("blank", blank, 1);
    chk("once", run, 0);
    // sync-driven single pattern, then pause and stop
    mode = PSE_MODE_VSYNC;
    wr_ent(4'h0, ent(3'h4, 4'h1, 5'h10, 2'h3, 1'b0, 1'b0));
    @(negedge clk);
    chk("stale", valid, 0);
    check_val(235, 470, 1, 0, 6'b000001);
    pulse(play);
    repeat (100) @(negedge clk);
    chk("nosync", expo, 0);
    i_src.vsync_pulse();
    wait_for(1'b1);
    chk("sync", {r, g, b, pd}, {3'b100, 8'h01});
    pulse(pause);
    @(negedge clk);
    chk("pause", {expo, run}, 2'b01);
    pulse(stop);
    @(negedge clk);
    chk("stop", run, 0);
    // gated external edges: low gate blocks the trigger and freezes exposure
    mode = PSE_MODE_INTEXT;
    gate_en = 1'b1;
    wr_ent(4'h0, ent(3'h6, 4'h1, 5'h0A, 2'h1, 1'b0, 1'b0));
    wr_ent(4'h1, ent(3'h2, 4'h1, 5'h0A, 2'h2, 1'b0, 1'b1));
    check_val(235, 470, 2, 0, 6'b000001);
    pulse(play);
    i_src.trig_pulse();
    repeat (4) @(negedge clk);
    chk("gated", {expo, run}, 2'b01);
    gate = 1'b1;
    repeat (20) @(negedge clk);
    chk("noedge", expo, 0);
    i_src.trig_pulse();
    chk("ext0", {expo, r, g, b, pd}, {1'b1, 3'b001, 8'h00});
    chk("index", ii, 6'h0A);
    gate = 1'b0;
    repeat (200) @(negedge clk);
    gate = 1'b1;
    n = 0;
    while (expo === 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    // 200 frozen cycles not counted, 3 cycles of the exposure already passed
    chk("frozen", n, 235 * 40 - 3);
    repeat (20) @(negedge clk);
    chk("nofall", expo, 0);
    i_src.trig_pulse();
    chk("rise", expo, 0);
    @(negedge clk);
    chk("fall", {expo, r, g, b, pd}, {1'b1, 3'b101, 8'h01});
    pulse(stop);
    @(negedge clk);
    chk("stop2", run, 0);
    end_sim();
  end
  // hang guard, well beyond the expected thirty thousand cycles
  initial begin
    #(60000 * 25);
    chk("watchdog", 0, 1);
    end_sim();
  end
endmodule : testbench
